// file: usbrw_map.vh
// Register offsets, field positions, reset values and timing for the resume/wake block
`ifndef USBRW_MAP_VH
`define USBRW_MAP_VH

// ==========================================
// Register offsets (byte addresses)
`define USBRW_CTRL_OFS 8'h00
`define USBRW_STATUS_OFS 8'h04
`define USBRW_MASK_OFS 8'h08
`define USBRW_STATE_OFS 8'h0C

// ==========================================
// Control fields
`define USBRW_CTRL_ENABLE_BIT 0
`define USBRW_CTRL_CLKGATE_BIT 1
`define USBRW_CTRL_PLLRUN_BIT 2
`define USBRW_CTRL_RESET 3'h0

// ==========================================
// Status and mask fields
`define USBRW_EVT_SUSPEND_BIT 0
`define USBRW_EVT_WAKE_BIT 1
`define USBRW_STATUS_RESET 2'h0
`define USBRW_MASK_RESET 2'h0

// ==========================================
// State fields
`define USBRW_STATE_SUSP_BIT 0
`define USBRW_STATE_RESUME_BIT 1
`define USBRW_STATE_IDLE_BIT 2

// ==========================================
// Timing
`define USBRW_PCLK_KHZ 40000
`define USBRW_SUSP_TIME_US 3000
`define USBRW_SUSP_CYCLES ((`USBRW_SUSP_TIME_US * `USBRW_PCLK_KHZ) / 1000)

`endif

// file: usbrw_sync.v
// Two-flop synchroniser for one asynchronous pin
module usbrw_sync (
  pclk,
  presetn,
  async_in,
  sync_out
);
  parameter RESET_VAL = 1'b0;
  input wire pclk;
  input wire presetn;
  input wire async_in;
  output wire sync_out;

  reg meta_r;
  reg sync_r;

  // ==========================================
  // First flop feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// file: usbrw_idle_det.v
// Counter that pulses once when the bus has stayed idle long enough
module usbrw_idle_det (
  pclk,
  presetn,
  arm,
  line_idle,
  hit
);
  parameter CYCLES = 120000;
  parameter CW = 20;
  input wire pclk;
  input wire presetn;
  input wire arm;
  input wire line_idle;
  output reg hit;

  localparam integer LAST_I = CYCLES - 1;
  localparam [CW-1:0] LAST = LAST_I[CW-1:0];

  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg done_r;

  // ==========================================
  // Count idle cycles; any activity restarts
  always @* begin
    cnt_nxt = cnt_r;
    if (!arm || !line_idle) begin
      cnt_nxt = {CW{1'b0}};
    end else if (cnt_r != LAST) begin
      cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // One pulse per idle stretch, not one per cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {CW{1'b0}};
      done_r <= 1'b0;
      hit <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hit <= arm && line_idle && (cnt_r == LAST) && !done_r;
      if (!arm || !line_idle) begin
        done_r <= 1'b0;
      end else if (cnt_r == LAST) begin
        done_r <= 1'b1;
      end
    end
  end
endmodule

// file: usbrw_top.v
// Suspend detection, resume wake-up and clock gating of the USB controller, APB slave
// ==========================================
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "usbrw_map.vh"

module usbrw_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  usb_dp,
  usb_dm,
  pll_locked,
  irq,
  usb_clk_run,
  pll_run,
  usb_active,
  suspend_state
);
  parameter SUSP_CYCLES = `USBRW_SUSP_CYCLES;
  parameter CNT_W = 20;

  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [7:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output reg pslverr;
  input wire usb_dp;
  input wire usb_dm;
  input wire pll_locked;
  output wire irq;
  output wire usb_clk_run;
  output wire pll_run;
  output wire usb_active;
  output wire suspend_state;

  // ==========================================
  // Pin synchronisers
  wire dp_s;
  wire dm_s;
  wire lock_s;

  usbrw_sync #(.RESET_VAL(1'b1)) u_sync_dp (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(usb_dp),
    .sync_out(dp_s)
  );

  usbrw_sync #(.RESET_VAL(1'b0)) u_sync_dm (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(usb_dm),
    .sync_out(dm_s)
  );

  usbrw_sync #(.RESET_VAL(1'b0)) u_sync_lock (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pll_locked),
    .sync_out(lock_s)
  );

  // Full-speed idle is the J state
  wire line_idle;
  assign line_idle = dp_s & ~dm_s;

  // ==========================================
  // Register state
  reg usb_enable_r;
  reg suspend_clock_gate_r;
  reg pll_run_enable_r;
  reg suspend_event_flag_r;
  reg cpu_wake_event_flag_r;
  reg [1:0] event_mask_r;
  reg resume_wake_flag_r;
  reg suspended_r;

  reg suspended_nxt;
  reg resume_wake_nxt;
  reg susp_flag_nxt;
  reg wake_flag_nxt;

  // ==========================================
  // APB decode
  wire wr_en;
  wire rd_setup;
  wire hit_ctrl;
  wire hit_status;
  wire hit_mask;
  wire hit_state;
  wire hit_any;

  // One comparator shape for every register slot
  function usbrw_addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      usbrw_addr_hit = (addr == ofs);
    end
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_ctrl = usbrw_addr_hit(paddr, `USBRW_CTRL_OFS);
  assign hit_status = usbrw_addr_hit(paddr, `USBRW_STATUS_OFS);
  assign hit_mask = usbrw_addr_hit(paddr, `USBRW_MASK_OFS);
  assign hit_state = usbrw_addr_hit(paddr, `USBRW_STATE_OFS);
  assign hit_any = hit_ctrl | hit_status | hit_mask | hit_state;

  // Zero wait states keep the slave simple
  assign pready = 1'b1;

  // ==========================================
  // Suspend detection
  wire idle_hit;

  // Counter held off while suspended, so no repeat detect
  usbrw_idle_det #(
    .CYCLES(SUSP_CYCLES),
    .CW(CNT_W)
  ) u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .arm(usb_enable_r & ~suspended_r),
    .line_idle(line_idle),
    .hit(idle_hit)
  );

  // Resume seen while suspended; pclk is never gated
  wire resume_hit;
  assign resume_hit = suspended_r & ~line_idle;

  // ==========================================
  // Sticky event flags, write one to clear
  wire clr_susp;
  wire clr_wake;
  assign clr_susp = wr_en & hit_status & pwdata[`USBRW_EVT_SUSPEND_BIT];
  assign clr_wake = wr_en & hit_status & pwdata[`USBRW_EVT_WAKE_BIT];

  always @* begin
    susp_flag_nxt = suspend_event_flag_r;
    if (clr_susp) begin
      susp_flag_nxt = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (idle_hit) begin
      susp_flag_nxt = 1'b1;
    end
  end

  always @* begin
    wake_flag_nxt = cpu_wake_event_flag_r;
    if (clr_wake) begin
      wake_flag_nxt = 1'b0;
    end
    if (resume_hit) begin
      wake_flag_nxt = 1'b1;
    end
  end

  // ==========================================
  // Suspend state
  always @* begin
    suspended_nxt = suspended_r;
    resume_wake_nxt = resume_wake_flag_r;
    if (!usb_enable_r) begin
      suspended_nxt = 1'b0;
      resume_wake_nxt = 1'b0;
    end else if (idle_hit) begin
      suspended_nxt = 1'b1;
    end else if (suspended_r) begin
      if (resume_hit) begin
        resume_wake_nxt = 1'b1;
      end
      // Leave only once resumed and the suspend flag is clear
      if (resume_wake_flag_r && !suspend_event_flag_r) begin
        suspended_nxt = 1'b0;
        resume_wake_nxt = 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_event_flag_r <= 1'b0;
      cpu_wake_event_flag_r <= 1'b0;
      suspended_r <= 1'b0;
      resume_wake_flag_r <= 1'b0;
    end else begin
      suspend_event_flag_r <= susp_flag_nxt;
      cpu_wake_event_flag_r <= wake_flag_nxt;
      suspended_r <= suspended_nxt;
      resume_wake_flag_r <= resume_wake_nxt;
    end
  end

  // ==========================================
  // Control and mask registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_enable_r <= 1'b0;
      suspend_clock_gate_r <= 1'b0;
      pll_run_enable_r <= 1'b0;
      event_mask_r <= `USBRW_MASK_RESET;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        usb_enable_r <= pwdata[`USBRW_CTRL_ENABLE_BIT];
        suspend_clock_gate_r <= pwdata[`USBRW_CTRL_CLKGATE_BIT];
        pll_run_enable_r <= pwdata[`USBRW_CTRL_PLLRUN_BIT];
      end else if (hit_mask) begin
        event_mask_r <= pwdata[1:0];
      end
    end
  end

  // ==========================================
  // Register images as software sees them
  wire [31:0] ctrl_word;
  wire [31:0] status_word;
  wire [31:0] mask_word;
  wire [31:0] state_word;
  wire [31:0] rd_word;

  assign ctrl_word = {29'h0, pll_run_enable_r, suspend_clock_gate_r, usb_enable_r};
  assign status_word = {30'h0, cpu_wake_event_flag_r, suspend_event_flag_r};
  assign mask_word = {30'h0, event_mask_r};
  // Raw line state lets firmware tell a stuck bus from a resume
  assign state_word = {29'h0, line_idle, resume_wake_flag_r, suspended_r};

  // Unmapped slots read zero, so a probe never sees stale data
  function [31:0] usbrw_rd_sel;
    input [3:0] hits;
    input [31:0] ctrl_w;
    input [31:0] status_w;
    input [31:0] mask_w;
    input [31:0] state_w;
    begin
      if (hits[0]) begin
        usbrw_rd_sel = ctrl_w;
      end else if (hits[1]) begin
        usbrw_rd_sel = status_w;
      end else if (hits[2]) begin
        usbrw_rd_sel = mask_w;
      end else if (hits[3]) begin
        usbrw_rd_sel = state_w;
      end else begin
        usbrw_rd_sel = 32'h00000000;
      end
    end
  endfunction

  assign rd_word = usbrw_rd_sel({hit_state, hit_mask, hit_status, hit_ctrl},
    ctrl_word, status_word, mask_word, state_word);

  // ==========================================
  // Read data and error, captured in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~hit_any;
      if (rd_setup) begin
        prdata <= rd_word;
      end
    end
  end

  // ==========================================
  // Interrupt and clock outputs
  wire [1:0] evt_vec;
  assign evt_vec = {cpu_wake_event_flag_r, suspend_event_flag_r};

  // Level output, asynchronous to any gated clock
  assign irq = |(evt_vec & event_mask_r);

  // 48 MHz reaches the controller only when ungated and locked
  assign usb_clk_run = usb_enable_r & ~suspend_clock_gate_r & lock_s;

  // PLL cannot stop before the gate is set
  assign pll_run = pll_run_enable_r | ~suspend_clock_gate_r;

  assign usb_active = usb_enable_r & ~suspended_r;
  assign suspend_state = suspended_r;
endmodule

// file: usbrw_props_properties.sv
// Port-level checks of the resume/wake block
`include "usbrw_map.vh"
module usbrw_props #(parameter SUSP_CYCLES = 20, parameter CNT_W = 20) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic usb_dp,
  input logic usb_dm,
  input logic pll_locked,
  input logic irq,
  input logic usb_clk_run,
  input logic pll_run,
  input logic usb_active,
  input logic suspend_state
);
  logic [1:0] mask_r;
  int idle_cnt_r;
  logic k_seen_r;
  // ==========================================
  // Shadow of mask and idle time seen while active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 2'h0;
      idle_cnt_r <= 0;
      k_seen_r <= 1'b0;
    end else begin
      k_seen_r <= suspend_state && (k_seen_r || (!usb_dp && usb_dm));
      if (psel && penable && pwrite && pready && paddr == `USBRW_MASK_OFS)
        mask_r <= pwdata[1:0];
      idle_cnt_r <= (usb_active && usb_dp && !usb_dm) ? idle_cnt_r + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence k_s;
    !usb_dp && usb_dm;
  endsequence
  sequence flag_clr_s;
    psel && penable && pwrite && pready && paddr == `USBRW_STATUS_OFS && pwdata[`USBRW_EVT_SUSPEND_BIT];
  endsequence
  sequence gate_set_s;
    psel && penable && pwrite && pready && paddr == `USBRW_CTRL_OFS && pwdata[`USBRW_CTRL_CLKGATE_BIT];
  endsequence
  // Eight idle cycles outlast the sync and flag latency of any resume
  sequence quiet_s;
    (suspend_state && !psel && usb_dp && !usb_dm) [*8];
  endsequence
  // ==========================================
  // Assertions
  AST_SUSP_MIN: assert property ($rose(suspend_state) |-> idle_cnt_r >= SUSP_CYCLES)
    else $error("suspend entered before idle time ran out");
  AST_SUSP_MAX: assert property (idle_cnt_r <= SUSP_CYCLES + 6)
    else $error("sustained idle did not suspend");
  AST_ACTIVE: assert property ((suspend_state && k_seen_r) ##0 flag_clr_s |-> ##[1:3] !suspend_state)
    else $error("suspend not left after resume and flag clear");
  AST_GATE: assert property (gate_set_s |=> !usb_clk_run)
    else $error("usb clock still runs after gate set");
  AST_STAY: assert property (quiet_s |=> suspend_state)
    else $error("suspend left without resume");
  AST_IRQ_MASK: assert property (irq |-> mask_r != 2'h0)
    else $error("irq with all events masked");
  AST_WAKE_IRQ: assert property ((suspend_state && mask_r[1]) ##0 k_s ##1 k_s [*2] |-> ##[1:3] irq)
    else $error("resume did not raise irq");
endmodule

// file: usbrw_host.sv
// Upstream host model driving the bus lines
module usbrw_host (
  input wire logic pclk,
  output logic usb_dp,
  output logic usb_dm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic traffic = 1'b0;
  logic [2:0] ph = 3'h0;
  int kcnt = 0;
  // Pull-up holds J when quiet; frame pulses stop the idle count
  always @(posedge pclk) begin
    ph <= ph + 3'h1;
    if (kcnt != 0) begin
      kcnt <= kcnt - 1;
      usb_dp <= 1'b0;
      usb_dm <= 1'b1;
    end else begin
      usb_dp <= !(traffic && ph == 3'h0);
      usb_dm <= traffic && ph == 3'h0;
    end
  end
  task automatic resume(input int n);
    @(posedge pclk);
    kcnt <= n;
    traffic <= 1'b1;
  endtask
  task automatic quiet();
    @(posedge pclk);
    traffic <= 1'b0;
  endtask
endmodule

// file: tb.sv
// Testbench: APB tasks and suspend/resume scenarios
`include "usbrw_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pll_locked = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, usb_dp, usb_dm, irq, usb_clk_run, pll_run, usb_active, suspend_state;
  int n_errors = 0, compares = 0;
  always #12.5 pclk = ~pclk;
  // Lock lags the run request by one cycle
  always @(posedge pclk) pll_locked <= pll_run;
  usbrw_top #(.SUSP_CYCLES(S)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .usb_dp, .usb_dm, .pll_locked, .irq, .usb_clk_run, .pll_run, .usb_active, .suspend_state);
  usbrw_host HOST (.pclk, .usb_dp, .usb_dm);
  // ==========================================
  // Tasks
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`USBRW_CTRL_OFS, 32'h0, "ctrl");
    rdc(`USBRW_STATUS_OFS, 32'h0, "status");
    rdc(`USBRW_MASK_OFS, 32'h0, "mask");
    rdc(8'h40, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    chk("pll_run", 32'h1, {31'h0, pll_run});
    rdc(`USBRW_STATE_OFS, 32'h4, "state");
    chk("pready", 32'h1, {31'h0, pready});
    chk("reset outs", 32'h0, {28'h0, irq, usb_active, suspend_state, usb_clk_run});
    wr(8'h40, 32'h7);
    chk("slverr wr", 32'h1, {31'h0, err});
    rdc(`USBRW_CTRL_OFS, 32'h0, "ctrl");
    $display("test reset done");
    wr(`USBRW_CTRL_OFS, 32'h5);
    wt(S + 8);
    chk("suspend", 32'h1, {31'h0, suspend_state});
    chk("irq", 32'h0, {31'h0, irq});
    rdc(`USBRW_STATUS_OFS, 32'h1, "status");
    rdc(`USBRW_STATE_OFS, 32'h5, "state");
    wr(`USBRW_MASK_OFS, 32'h3);
    wt(1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`USBRW_STATUS_OFS, 32'h1);
    wr(`USBRW_CTRL_OFS, 32'h3);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    chk("pll_run", 32'h0, {31'h0, pll_run});
    chk("clk_run", 32'h0, {31'h0, usb_clk_run});
    wt(S);
    chk("suspend", 32'h1, {31'h0, suspend_state});
    HOST.resume(4);
    wt(8);
    chk("suspend", 32'h0, {31'h0, suspend_state});
    chk("active", 32'h1, {31'h0, usb_active});
    chk("irq", 32'h1, {31'h0, irq});
    rdc(`USBRW_STATUS_OFS, 32'h2, "status");
    wr(`USBRW_CTRL_OFS, 32'h7);
    wr(`USBRW_CTRL_OFS, 32'h5);
    wr(`USBRW_STATUS_OFS, 32'h2);
    wt(4);
    chk("clk_run", 32'h1, {31'h0, usb_clk_run});
    chk("irq", 32'h0, {31'h0, irq});
    $display("test gated resume done");
    HOST.quiet();
    wt(S + 10);
    chk("suspend", 32'h1, {31'h0, suspend_state});
    HOST.resume(4);
    wt(8);
    chk("suspend", 32'h1, {31'h0, suspend_state});
    wr(`USBRW_STATUS_OFS, 32'h3);
    wt(2);
    chk("suspend", 32'h0, {31'h0, suspend_state});
    chk("active", 32'h1, {31'h0, usb_active});
    $display("test late flag clear done");
    report_and_stop();
  end
  // Whole run needs well under 500 cycles
  initial begin
    #(25 * 2000);
    n_errors++;
    report_and_stop();
  end
endmodule
bind usbrw_top usbrw_props #(.SUSP_CYCLES(SUSP_CYCLES), .CNT_W(CNT_W)) PROPS (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .usb_dp, .usb_dm, .pll_locked, .irq, .usb_clk_run,
  .pll_run, .usb_active, .suspend_state);
